// ---- hdl/ebc_pkg.sv ----
// Package of the external bus cycle sequencer: register map, field layout,
// reset values and phase states.
// Assumes a 10 MHz system clock; one phase tick is one system clock period.
package ebc_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CFG0 = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // ----------------------------------------
   // Chip select timing fields
   // ----------------------------------------
   localparam int CFG_W = 16;
   localparam int CFG_AB_POS = 0;
   localparam int CFG_WIN_LSB = 1;
   localparam int CFG_C_LSB = 3;
   localparam int CFG_D_POS = 5;
   localparam int CFG_E_LSB = 6;
   localparam int CFG_F_LSB = 11;
   localparam int CFG_RDY_EN = 13;
   localparam int CFG_RDY_POL = 14;
   localparam int CFG_RDY_ASY = 15;
   localparam logic [15:0] CFG_RST = 16'h0000;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_MUX = 0;
   localparam int CTRL_REFCLK = 1;
   localparam int CTRL_EN = 2;
   localparam logic [2:0] CTRL_RST = 3'h6;

   // ----------------------------------------
   // Phase states, Gray from ST_IDLE through ST_F; the return to ST_IDLE is not
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_AB = 3'h1,
      ST_C = 3'h3,
      ST_D = 3'h2,
      ST_E = 3'h6,
      ST_F = 3'h7
   } ebc_state_t;

endpackage

// ---- hdl/ebc_xfer_if.sv ----
// Interface carrying one bus request and its answer between the link port
// and the sequencer.
// Assumes toggle signalling: fields stand still while a toggle is unanswered.
`timescale 1ns/1ps
interface ebc_xfer_if #(parameter int ADDR_W = 24, DATA_W = 16, CS_W = 2);
   logic req_tgl;
   logic write;
   logic hbe;
   logic [CS_W-1:0] cs;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic ack_tgl;
   logic [DATA_W-1:0] rdata;

   modport link (output req_tgl, write, hbe, cs, addr, wdata, input ack_tgl, rdata);
   modport seq (input req_tgl, write, hbe, cs, addr, wdata, output ack_tgl, rdata);
endinterface

// ---- hdl/ebc_link_port.sv ----
// Request port of the bus sequencer, running on the link clock.
// Assumes the sequencer answers each request toggle with one answer toggle.
`timescale 1ns/1ps
module ebc_link_port import ebc_pkg::*; #(
   parameter int ADDR_W = 24,
   parameter int DATA_W = 16,
   parameter int CS_W = 2
) (
   // Clock and reset
   input wire logic link_clk,
   input wire logic rst_b,
   // User request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_hbe,
   input wire logic [CS_W-1:0] req_cs,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic done,
   output logic [DATA_W-1:0] done_rdata,
   // Sequencer side
   ebc_xfer_if.link x
);
   logic pend, next_pend;
   logic tgl, next_tgl;
   logic write_q, next_write_q, hbe_q, next_hbe_q;
   logic [CS_W-1:0] cs_q, next_cs_q;
   logic [ADDR_W-1:0] addr_q, next_addr_q;
   logic [DATA_W-1:0] wdata_q, next_wdata_q, rd_q, next_rd_q;
   logic done_q, next_done_q;
   logic ack_s1, ack_s2, ack_seen, next_ack_seen;

   // ----------------------------------------
   // Answer synchroniser
   // ----------------------------------------
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= x.ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   // ----------------------------------------
   // Request holding
   // ----------------------------------------
   always_comb begin
      next_pend = pend;
      next_tgl = tgl;
      next_write_q = write_q;
      next_hbe_q = hbe_q;
      next_cs_q = cs_q;
      next_addr_q = addr_q;
      next_wdata_q = wdata_q;
      next_rd_q = rd_q;
      next_ack_seen = ack_seen;
      next_done_q = 1'b0;
      if (!pend && req_valid) begin
         next_pend = 1'b1;
         next_tgl = ~tgl;
         next_write_q = req_write;
         next_hbe_q = req_hbe;
         next_cs_q = req_cs;
         next_addr_q = req_addr;
         next_wdata_q = req_wdata;
      end else if (pend && ack_s2 != ack_seen) begin
         // Answer data are still since the sequencer holds them
         next_pend = 1'b0;
         next_ack_seen = ack_s2;
         next_rd_q = x.rdata;
         next_done_q = 1'b1;
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 1'b0;
         tgl <= 1'b0;
         write_q <= 1'b0;
         hbe_q <= 1'b0;
         cs_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         rd_q <= '0;
         ack_seen <= 1'b0;
         done_q <= 1'b0;
      end else begin
         pend <= next_pend;
         tgl <= next_tgl;
         write_q <= next_write_q;
         hbe_q <= next_hbe_q;
         cs_q <= next_cs_q;
         addr_q <= next_addr_q;
         wdata_q <= next_wdata_q;
         rd_q <= next_rd_q;
         ack_seen <= next_ack_seen;
         done_q <= next_done_q;
      end
   end

   assign req_ready = !pend;
   assign done = done_q;
   assign done_rdata = rd_q;
   assign x.req_tgl = tgl;
   assign x.write = write_q;
   assign x.hbe = hbe_q;
   assign x.cs = cs_q;
   assign x.addr = addr_q;
   assign x.wdata = wdata_q;

endmodule // ebc_link_port

// ---- hdl/ebc_seq.sv ----
// External bus cycle sequencer: five timed phases per cycle, READY stretching,
// per chip select timing registers and the reference clock output.
// Assumes user requests arrive on link_clk and the bus pins are clocked by sys_clk.
// Function
// RL1: Every bus cycle runs address setup, command delay, data setup, access and hold in that order.
// RL2: Each phase length comes from the timing register of the cycle's chip select.
// RL3: Address setup lasts 1 or 2 ticks, plus 0 to 3 ticks when the chip select window changes.
// RL4: Command delay lasts 0 to 3 ticks, data setup 0 or 1 tick, hold 0 to 3 ticks.
// RL5: Access lasts 1 to 32 ticks and may be stretched by READY from outside.
// RL6: Read data are caught on the edge that ends the access and raises the read strobe.
// RL7: The system clock is driven out as the bus reference clock with its driver enabled. Code: the enable follows CTRL_REFCLK, set at reset, clearable.
// RL8: READY polarity is selectable.
// RL9: Synchronous READY is used as synchronised; asynchronous READY passes one more stage.
// RL10: At each READY sample in access an inactive READY adds a wait tick, an active one ends it.
// RL11: The outside party withdraws READY before the first sample of the next READY cycle.
// RL12: A tick is one system clock; each phase counts down and hands on when exhausted.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
module ebc_seq import ebc_pkg::*; #(
   parameter int NUM_CS = 4,
   parameter int ADDR_W = 24,
   parameter int DATA_W = 16
) (
   // Clocks and reset
   input wire logic sys_clk,
   input wire logic link_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // User requests on link_clk
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_hbe,
   input wire logic [$clog2(NUM_CS)-1:0] req_cs,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic done,
   output logic [DATA_W-1:0] done_rdata,
   // Bus pins
   output logic clock_output_signal,
   output logic refclk_drv_en,
   output logic [ADDR_W-1:0] addr_out,
   output logic ale,
   output logic [NUM_CS-1:0] cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic high_byte_enable,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic ready_pin
);
   localparam int CS_W = $clog2(NUM_CS);

   ebc_xfer_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CS_W(CS_W)) x ();

   ebc_link_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CS_W(CS_W)) u_link (
      .link_clk(link_clk),
      .rst_b(rst_b),
      .req_valid(req_valid),
      .req_write(req_write),
      .req_hbe(req_hbe),
      .req_cs(req_cs),
      .req_addr(req_addr),
      .req_wdata(req_wdata),
      .req_ready(req_ready),
      .done(done),
      .done_rdata(done_rdata),
      .x(x.link)
   );

   // ----------------------------------------
   // Phase helpers
   // ----------------------------------------
   function automatic logic [5:0] plen(input ebc_state_t s, input logic [CFG_W-1:0] c);
      logic [5:0] n;
      case (s)
         ST_C: n = {4'h0, c[CFG_C_LSB +: 2]};
         ST_D: n = {5'h00, c[CFG_D_POS]};
         ST_E: n = {1'b0, c[CFG_E_LSB +: 5]} + 6'h01;
         ST_F: n = {4'h0, c[CFG_F_LSB +: 2]};
         default: n = 6'h00;
      endcase
      return n;
   endfunction

   function automatic ebc_state_t step(input ebc_state_t s);
      ebc_state_t n;
      case (s)
         ST_AB: n = ST_C;
         ST_C: n = ST_D;
         ST_D: n = ST_E;
         ST_E: n = ST_F;
         default: n = ST_IDLE;
      endcase
      return n;
   endfunction

   // Zero length phases are skipped without costing a tick
   function automatic ebc_state_t advance(input ebc_state_t s, input logic [CFG_W-1:0] c);
      ebc_state_t n;
      n = step(s);
      for (int i = 0; i < 3; i++) begin
         if (n != ST_IDLE && plen(n, c) == 6'h00) begin
            n = step(n);
         end
      end
      return n;
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [CFG_W-1:0] cfg [NUM_CS];
   logic [CFG_W-1:0] next_cfg [NUM_CS];
   logic [2:0] ctrl, next_ctrl;
   logic [31:0] next_reg_rdata;
   logic cfg_hit;
   logic [CS_W-1:0] cfg_idx;
   ebc_state_t state, next_state;
   logic [CS_W-1:0] cur_cs, next_cur_cs, last_cs, next_last_cs;
   logic ready_act;

   // Chip select count is limited to four so the window fits below control
   assign cfg_idx = reg_addr[2 +: CS_W];
   assign cfg_hit = reg_addr[1:0] == 2'h0 && reg_addr < OFS_CFG0 + 8'(4 * NUM_CS);

   always_comb begin
      next_cfg = cfg;
      next_ctrl = ctrl;
      next_reg_rdata = 32'h0000_0000;
      if (reg_wr) begin
         // RL2 per select timing
         if (cfg_hit) begin
            next_cfg[cfg_idx] = reg_wdata[CFG_W-1:0];
         end else if (reg_addr == OFS_CTRL) begin
            next_ctrl = reg_wdata[2:0];
         end
      end
      if (reg_rd) begin
         if (cfg_hit) begin
            next_reg_rdata = {16'h0000, cfg[cfg_idx]};
         end else if (reg_addr == OFS_CTRL) begin
            next_reg_rdata = {29'h0, ctrl};
         end else if (reg_addr == OFS_STAT) begin
            next_reg_rdata = {24'h0, 1'b0, ready_act, 2'(last_cs), 1'b0, state};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_CS; i++) begin
            cfg[i] <= CFG_RST;
         end
         ctrl <= CTRL_RST;
         reg_rdata <= 32'h0000_0000;
      end else begin
         cfg <= next_cfg;
         ctrl <= next_ctrl;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ----------------------------------------
   // Reference clock
   // ----------------------------------------
   // RL7 system clock out
   assign clock_output_signal = sys_clk;
   assign refclk_drv_en = ctrl[CTRL_REFCLK];

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic rq_s1, rq_s2, rdy_s1, rdy_s2, rdy_s3;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rq_s1 <= 1'b0;
         rq_s2 <= 1'b0;
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         rdy_s3 <= 1'b0;
      end else begin
         rq_s1 <= x.req_tgl;
         rq_s2 <= rq_s1;
         rdy_s1 <= ready_pin;
         rdy_s2 <= rdy_s1;
         rdy_s3 <= rdy_s2;
      end
   end

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   logic [4:0] cnt, next_cnt;
   logic [CFG_W-1:0] cur_cfg, next_cur_cfg;
   logic cur_write, next_cur_write, cur_hbe, next_cur_hbe;
   logic [ADDR_W-1:0] cur_addr, next_cur_addr;
   logic [DATA_W-1:0] cur_wdata, next_cur_wdata, rdata, next_rdata;
   logic ack_tgl, next_ack_tgl, rq_seen, next_rq_seen;
   logic [NUM_CS-1:0] next_cs_n;
   logic next_ale, next_rd_n, next_wr_n, next_hbe_pin, next_oe;
   logic [DATA_W-1:0] next_dout;
   logic [2:0] ab_total;
   logic go;
   ebc_state_t adv;

   // RL8 RL9 polarity, extra stage when asynchronous
   assign ready_act = (cur_cfg[CFG_RDY_ASY] ? rdy_s3 : rdy_s2) == cur_cfg[CFG_RDY_POL];

   // RL3 window change adds ticks
   assign ab_total = 3'h1 + {2'h0, cfg[x.cs][CFG_AB_POS]}
      + (x.cs != last_cs ? {1'b0, cfg[x.cs][CFG_WIN_LSB +: 2]} : 3'h0);

   assign adv = advance(state, cur_cfg);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cur_cfg = cur_cfg;
      next_cur_write = cur_write;
      next_cur_hbe = cur_hbe;
      next_cur_cs = cur_cs;
      next_cur_addr = cur_addr;
      next_cur_wdata = cur_wdata;
      next_last_cs = last_cs;
      next_rdata = rdata;
      next_ack_tgl = ack_tgl;
      next_rq_seen = rq_seen;
      go = 1'b0;
      case (state)
         ST_IDLE: begin
            if (ctrl[CTRL_EN] && rq_s2 != rq_seen) begin
               // RL2 RL3 latch timing, start address setup
               next_rq_seen = rq_s2;
               next_cur_cfg = cfg[x.cs];
               next_cur_write = x.write;
               next_cur_hbe = x.hbe;
               next_cur_cs = x.cs;
               next_last_cs = x.cs;
               next_cur_addr = x.addr;
               next_cur_wdata = x.wdata;
               next_state = ST_AB;
               next_cnt = 5'(ab_total - 3'h1);
            end
         end
         ST_E: begin
            // RL5 access count down
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else if (cur_cfg[CFG_RDY_EN] && !ready_act) begin
               // RL10 wait tick
               next_cnt = 5'h00;
            end else begin
               // RL6 catch read data at strobe rise
               if (!cur_write) begin
                  next_rdata = data_in;
               end
               go = 1'b1;
            end
         end
         default: begin
            // RL12 count down the tick
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else begin
               go = 1'b1;
            end
         end
      endcase
      // RL1 RL4 fixed order, empty phases skipped
      if (go) begin
         next_state = adv;
         next_cnt = 5'(plen(adv, cur_cfg) - 6'h01);
         if (adv == ST_IDLE) begin
            next_cnt = 5'h00;
            next_ack_tgl = ~ack_tgl;
         end
      end
      // Pin values registered alongside the state
      next_cs_n = '1;
      if (next_state != ST_IDLE) begin
         next_cs_n[next_cur_cs] = 1'b0;
      end
      next_ale = next_state == ST_AB;
      next_rd_n = !(next_state == ST_E && !next_cur_write);
      next_wr_n = !(next_state == ST_E && next_cur_write);
      next_hbe_pin = next_state != ST_IDLE && next_cur_hbe;
      next_dout = next_cur_wdata;
      next_oe = 1'b0;
      if (next_state == ST_AB && ctrl[CTRL_MUX]) begin
         next_dout = next_cur_addr[DATA_W-1:0];
         next_oe = 1'b1;
      end else if (next_cur_write && (next_state == ST_D || next_state == ST_E || next_state == ST_F)) begin
         next_oe = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cnt <= 5'h00;
         cur_cfg <= CFG_RST;
         cur_write <= 1'b0;
         cur_hbe <= 1'b0;
         cur_cs <= '0;
         last_cs <= '0;
         cur_addr <= '0;
         cur_wdata <= '0;
         rdata <= '0;
         ack_tgl <= 1'b0;
         rq_seen <= 1'b0;
         cs_n <= '1;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         high_byte_enable <= 1'b0;
         data_out <= '0;
         data_oe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cur_cfg <= next_cur_cfg;
         cur_write <= next_cur_write;
         cur_hbe <= next_cur_hbe;
         cur_cs <= next_cur_cs;
         last_cs <= next_last_cs;
         cur_addr <= next_cur_addr;
         cur_wdata <= next_cur_wdata;
         rdata <= next_rdata;
         ack_tgl <= next_ack_tgl;
         rq_seen <= next_rq_seen;
         cs_n <= next_cs_n;
         ale <= next_ale;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         high_byte_enable <= next_hbe_pin;
         data_out <= next_dout;
         data_oe <= next_oe;
      end
   end

   assign addr_out = cur_addr;
   assign x.ack_tgl = ack_tgl;
   assign x.rdata = rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_enter_ab;
      state == ST_IDLE ##1 state == ST_AB;
   endsequence
   sequence s_read_end;
      state == ST_E && next_state != ST_E && !cur_write;
   endsequence

   ab_exit_a: assert property (state == ST_AB && cnt == 5'h00 |=> state inside {ST_C, ST_D, ST_E}) // RL1
      else $error("address setup left to a wrong phase");
   e_exit_a: assert property (state == ST_E && next_state != ST_E |=> state inside {ST_F, ST_IDLE}) // RL1
      else $error("access left to a wrong phase");
   ab_len_a: assert property (s_enter_ab |-> cnt <= 5'h04 && cnt >= {4'h0, cur_cfg[CFG_AB_POS]}) // RL3
      else $error("address setup length out of range");
   ab_same_a: assert property (s_enter_ab ##0 (cur_cs == $past(last_cs)) |-> cnt == {4'h0, cur_cfg[CFG_AB_POS]}) // RL3
      else $error("window extension without window change");
   cmd_len_a: assert property (state == ST_C && $past(state) != ST_C |-> cnt == {3'h0, cur_cfg[CFG_C_LSB +: 2]} - 5'h01) // RL4
      else $error("command delay length wrong");
   access_len_a: assert property (state == ST_E && $past(state) != ST_E |-> cnt == cur_cfg[CFG_E_LSB +: 5]) // RL5
      else $error("access length wrong");
   cs_drive_a: assert property (state != ST_IDLE |-> !cs_n[cur_cs] && $countones(~cs_n) == 1) // RL2
      else $error("chip select not driven for cycle");
   rdata_catch_a: assert property (s_read_end |=> !rd_n == 1'b0 && rdata == $past(data_in)) // RL6
      else $error("read data not caught at strobe rise");
   ready_wait_a: assert property (state == ST_E && cnt == 5'h00 && cur_cfg[CFG_RDY_EN] && !ready_act
      |=> state == ST_E && cnt == 5'h00) // RL10
      else $error("wait tick not inserted");
   ready_end_a: assert property (state == ST_E && cnt == 5'h00 && ready_act |=> state != ST_E) // RL10
      else $error("active ready did not end access");
   ready_async_a: assert property (cur_cfg[CFG_RDY_ASY] // RL9
      |-> ready_act == ($past(rdy_s1, 2) == cur_cfg[CFG_RDY_POL]))
      else $error("asynchronous ready missing extra stage");
   tick_count_a: assert property (state != ST_IDLE && cnt != 5'h00 |=> state == $past(state) && cnt == $past(cnt) - 5'h01) // RL12
      else $error("phase tick count wrong");
   refclk_en_a: assert property (reg_wr && reg_addr == OFS_CTRL |=> refclk_drv_en == $past(reg_wdata[CTRL_REFCLK])) // RL7
      else $error("reference clock driver enable not updated");

endmodule // ebc_seq

// ---- bench/ebc_mem_model.sv ----
// Behavioural external memory with READY, measuring each bus cycle's phases.
// Assumes active low chip selects and commands, bus clocked by sys_clk.
`timescale 1ns/1ps
module ebc_mem_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bus pins
   input wire logic [23:0] addr_out,
   input wire logic ale,
   input wire logic [3:0] cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [15:0] data_out,
   output logic [15:0] data_in,
   output logic ready_pin,
   // Bench control and phase measures
   input wire logic [7:0] rdy_delay,
   input wire logic rdy_pol,
   output logic [7:0] ale_len,
   output logic [7:0] gap_len,
   output logic [7:0] cmd_len,
   output logic [7:0] hold_len
);
   logic [15:0] mem [16];
   logic [15:0] noise;
   logic cs_q;
   logic seen;
   wire cmd = !rd_n || !wr_n;
   wire sel = !(&cs_n);
   // Read data only while read strobe low; noise otherwise so stale data cannot pass
   assign data_in = !rd_n ? mem[addr_out[3:0]] : noise;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         noise <= 16'h5A3C;
         cs_q <= 1'h0;
         seen <= 1'h0;
         ready_pin <= !rdy_pol;
         {ale_len, gap_len, cmd_len, hold_len} <= 32'h0;
      end else begin
         noise <= ~noise;
         cs_q <= sel;
         if (!wr_n) mem[addr_out[3:0]] <= data_out;
         // READY in step, selectable level, dropped when command ends
         ready_pin <= (cmd && cmd_len >= rdy_delay) ~^ rdy_pol;
         if (sel && !cs_q) begin
            {ale_len, gap_len, cmd_len, hold_len} <= {7'h0, ale, 24'h0};
            seen <= 1'h0;
         end else if (sel) begin
            if (ale) ale_len <= ale_len + 8'h1;
            else if (cmd) begin
               cmd_len <= cmd_len + 8'h1;
               seen <= 1'h1;
            end else if (seen) hold_len <= hold_len + 8'h1;
            else gap_len <= gap_len + 8'h1;
         end
      end
   end
endmodule // ebc_mem_model

// ---- bench/ebc_seq_tb.sv ----
// Self-checking bench of the bus sequencer: registers, phases, READY, reference clock.
// Assumes the memory model on the bus pins and requests issued on link_clk.
`timescale 1ns/1ps
module ebc_seq_tb import ebc_pkg::*; ;
   logic sys_clk = 1'h0, link_clk = 1'h0, rst_b = 1'h0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_hbe = 1'h0;
   logic req_ready, done, clock_output_signal, refclk_drv_en, ale, rd_n, wr_n, high_byte_enable, data_oe, ready_pin;
   logic [1:0] req_cs = 2'h0;
   logic [23:0] req_addr = 24'h0, addr_out;
   logic [15:0] req_wdata = 16'h0, done_rdata, data_in, data_out, cfg;
   logic [3:0] cs_n;
   logic [7:0] rdy_delay = 8'h4, ale_len, gap_len, cmd_len, hold_len;
   logic rdy_pol = 1'h1;
   logic [15:0] mux_seen = 16'h0;
   logic hbe_seen = 1'h0, oe_seen = 1'h0;
   int failures = 0, checked = 0;
   int ab[3] = '{0, 1, 0}, win[3] = '{0, 3, 2}, c[3] = '{0, 3, 2};
   int d[3] = '{0, 1, 0}, e[3] = '{1, 32, 5}, f[3] = '{0, 3, 1};

   ebc_seq i_ebc_seq (.sys_clk, .link_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .req_valid, .req_write, .req_hbe, .req_cs, .req_addr, .req_wdata, .req_ready, .done, .done_rdata,
      .clock_output_signal, .refclk_drv_en, .addr_out, .ale, .cs_n, .rd_n, .wr_n, .high_byte_enable,
      .data_in, .data_out, .data_oe, .ready_pin);
   ebc_mem_model i_ebc_mem_model (.sys_clk, .rst_b, .addr_out, .ale, .cs_n, .rd_n, .wr_n, .data_out,
      .data_in, .ready_pin, .rdy_delay, .rdy_pol, .ale_len, .gap_len, .cmd_len, .hold_len);

   initial forever #50 sys_clk = ~sys_clk;
   // Pin levels during a cycle, taken before the edge updates them
   always @(posedge sys_clk) begin
      if (ale && data_oe) mux_seen <= data_out;
      if (!(&cs_n)) hbe_seen <= high_byte_enable;
      if (!rd_n || !wr_n) oe_seen <= data_oe;
   end
   initial begin
      #17;
      forever #40 link_clk = ~link_clk;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_rng(input string name, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
      checked++;
      if ((got >= lo && got <= hi) !== 1'h1) begin
         failures++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic reg_check(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      @(negedge sys_clk);
      check(name, exp, reg_rdata);
   endtask
   // One request, held until taken, then a bounded wait for its done pulse
   task automatic xfer(input logic wr, input logic [1:0] cs, input logic [23:0] a, input logic [15:0] v);
      int n;
      n = 0;
      @(posedge link_clk);
      req_valid <= 1'h1;
      req_write <= wr;
      req_hbe <= wr;
      req_cs <= cs;
      req_addr <= a;
      req_wdata <= v;
      do @(posedge link_clk); while (req_ready !== 1'h1 && ++n < 50);
      req_valid <= 1'h0;
      n = 0;
      do @(negedge link_clk); while (done !== 1'h1 && ++n < 400);
      check("done", 32'h1, {31'h0, done});
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("MISMATCH watchdog expected finish seen hang");
      conclude();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'h1;
      reg_check("ctrl_rst", OFS_CTRL, 32'h6);
      for (int i = 0; i < 4; i++) reg_check("cfg_rst", OFS_CFG0 + 8'(4 * i), 32'h0);
      reg_check("stat_rst", OFS_STAT, 32'h40);
      reg_write(8'h40, 32'hFFFF);
      reg_check("unmapped", 8'h40, 32'h0);
      for (int k = 0; k < 4; k++) begin
         #30 check("refclk", {31'h0, sys_clk}, {31'h0, clock_output_signal});
      end
      reg_write(OFS_CTRL, 32'h4);
      @(negedge sys_clk);
      check("drv_off", 32'h0, {31'h0, refclk_drv_en});
      reg_write(OFS_CTRL, 32'h6);
      @(negedge sys_clk);
      check("drv_on", 32'h1, {31'h0, refclk_drv_en});
      // Chip selects 0 to 2 each get their own timing; a write moving to a new select pays the window extra
      for (int i = 0; i < 3; i++) begin
         cfg = 16'(ab[i] << CFG_AB_POS | win[i] << CFG_WIN_LSB | c[i] << CFG_C_LSB | d[i] << CFG_D_POS
            | (e[i] - 1) << CFG_E_LSB | f[i] << CFG_F_LSB);
         reg_write(OFS_CFG0 + 8'(4 * i), {16'hFFFF, cfg});
         reg_check("cfg_rw", OFS_CFG0 + 8'(4 * i), {16'h0, cfg});
         xfer(1'h1, 2'(i), 24'h100 + 24'(i), 16'hA5C0 + 16'(i));
         check("ab_wr", 1 + ab[i] + (i > 0 ? win[i] : 0), {24'h0, ale_len});
         check("cd_wr", c[i] + d[i], {24'h0, gap_len});
         check("e_wr", e[i], {24'h0, cmd_len});
         check("f_wr", f[i], {24'h0, hold_len});
         check("pins_wr", 32'h3, {30'h0, hbe_seen, oe_seen});
         xfer(1'h0, 2'(i), 24'h100 + 24'(i), 16'h0);
         check("ab_rd", 1 + ab[i], {24'h0, ale_len});
         check("e_rd", e[i], {24'h0, cmd_len});
         check("f_rd", f[i], {24'h0, hold_len});
         check("pins_rd", 32'h0, {30'h0, hbe_seen, oe_seen});
         check("rdata", 16'hA5C0 + 16'(i), {16'h0, done_rdata});
      end
      // Synchronous active-high READY, then asynchronous active-low with its extra stage
      for (int m = 0; m < 2; m++) begin
         rdy_pol <= 1'(m == 0);
         reg_write(OFS_CFG0 + 8'hC, 32'(1 << CFG_RDY_EN | (m == 0) << CFG_RDY_POL | m << CFG_RDY_ASY));
         xfer(1'h0, 2'h3, 24'h100, 16'h0);
         check_rng("rdy_len", 8'(6 + m), 8'(10 + m), cmd_len);
         check("rdy_data", 32'hA5C0, {16'h0, done_rdata});
      end
      // Multiplexed mode: address travels on the data pins during address setup
      reg_write(OFS_CTRL, 32'h7);
      xfer(1'h1, 2'h3, 24'h00ABCD, 16'h1357);
      check("mux_addr", 32'hABCD, {16'h0, mux_seen});
      reg_check("stat_cs", OFS_STAT, 32'h30);
      conclude();
   end
endmodule // ebc_seq_tb
